/* hw/rorr_pkg.sv */
`default_nettype none
package rorr_pkg;

  // ==========================================================================
  // widths
  localparam int TAG_W   = 6;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int STATE_W = 3;
  localparam int INT_W   = 3;

  typedef logic [TAG_W-1:0]  rorr_tag_t;
  typedef logic [ADDR_W-1:0] rorr_addr_t;
  typedef logic [DATA_W-1:0] rorr_data_t;
  typedef logic [INT_W-1:0]  rorr_int_t;

  // ==========================================================================
  // register byte addresses
  localparam rorr_addr_t REG_CTRL       = 8'h00;
  localparam rorr_addr_t REG_STATUS     = 8'h04;
  localparam rorr_addr_t REG_INT_STATUS = 8'h08;
  localparam rorr_addr_t REG_INT_MASK   = 8'h0C;
  localparam rorr_addr_t REG_TAGS       = 8'h10;

  // ==========================================================================
  // field positions
  localparam int CTRL_EN_BIT       = 0;
  localparam int CTRL_ABORT_BIT    = 1;
  localparam int STAT_LINK_OK_BIT  = 0;
  localparam int STAT_HALT_BIT     = 1;
  localparam int STAT_STATE_LSB    = 4;
  localparam int INT_RETRY_BIT     = 0;
  localparam int INT_RESUMED_BIT   = 1;
  localparam int INT_HANDOFF_BIT   = 2;
  localparam int TAGS_RETRY_LSB    = 0;
  localparam int TAGS_NEXT_LSB     = 8;
  localparam int TAGS_OLDEST_LSB   = 16;

  // ==========================================================================
  // reset values
  localparam logic [1:0] CTRL_RESET  = 2'h0;
  localparam rorr_int_t  INT_RESET   = 3'h0;
  localparam rorr_tag_t  TAG_RESET   = 6'h00;
  localparam rorr_data_t DATA_RESET  = 32'h0000_0000;

  // ==========================================================================
  // machine states
  typedef enum logic [STATE_W-1:0] {
    st_inactive,
    st_armed,
    st_halting,
    st_replay_prep
  } rorr_state_e;

endpackage : rorr_pkg
`default_nettype wire

/* hw/rorr_scoreboard.sv */
`default_nettype none
// ============================================================================
// outstanding sequence tag window: oldest unacknowledged up to next to send
module rorr_scoreboard #(
  parameter int TAG_W = 6
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // transmit and acknowledge events
  input  wire logic             pkt_start,
  input  wire logic             ack_valid,
  input  wire logic [TAG_W-1:0] ack_tag,
  // replay rewind
  input  wire logic             rewind,
  input  wire logic [TAG_W-1:0] rewind_tag,
  // window
  output logic      [TAG_W-1:0] next_tag,
  output logic      [TAG_W-1:0] oldest_tag
);

  localparam logic [TAG_W-1:0] TAG_ONE  = TAG_W'(1);
  localparam logic [TAG_W-1:0] TAG_ZERO = TAG_W'(0);

  // rewind wins: every packet from the refused tag on goes out again
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      next_tag <= TAG_ZERO;
    end else if (rewind) begin
      next_tag <= rewind_tag;
    end else if (pkt_start) begin
      next_tag <= next_tag + TAG_ONE;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      oldest_tag <= TAG_ZERO;
    end else if (rewind) begin
      oldest_tag <= rewind_tag;
    end else if (ack_valid) begin
      oldest_tag <= ack_tag + TAG_ONE;
    end
  end

endmodule : rorr_scoreboard
`default_nettype wire

/* hw/rorr_core.sv */
// Operation
// - after reset stay inactive while the transmit port is not enabled
// - port enable needs link initialization done and the software enable bit
// - enabling the port moves inactive to armed
// - disabling the port while armed returns to inactive
// - only an error-free packet-retry symbol triggers retry handling
// - a valid packet-retry symbol moves armed to halting
// - halting clears link-ok, sets replay-halt, stops new packets
// - stop done moves halting to replay preparation until recovery completes
// - resend the refused tag's packet and every packet after it
// - clear replay-halt and set link-ok, then rewind scoreboard
// - packet-not-accepted or transmit error in preparation hands off cleanly
// - replay preparation sends a restart-from-retry symbol
// - retransmission started and recovery done returns to armed
//
// Our own choices: the register offsets and the strobed register port.
`default_nettype none
module rorr_core
  import rorr_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // link initialization status pin
  input  wire logic                 init_done,
  // received control symbols
  input  wire logic                 rx_retry_valid,
  input  wire logic                 rx_sym_err,
  input  wire rorr_pkg::rorr_tag_t  rx_retry_tag,
  input  wire logic                 rx_pna_valid,
  input  wire logic                 rx_ack_valid,
  input  wire rorr_pkg::rorr_tag_t  rx_ack_tag,
  // transmitter status
  input  wire logic                 tx_pkt_start,
  input  wire rorr_pkg::rorr_tag_t  tx_pkt_tag,
  input  wire logic                 tx_pkt_active,
  input  wire logic                 tx_port_err,
  input  wire logic                 err_done,
  // transmitter control
  output logic                      link_ok,
  output logic                      replay_halt,
  output logic                      tx_abort,
  output logic                      send_restart,
  output logic                      err_handoff,
  output rorr_pkg::rorr_tag_t       replay_tag,
  output rorr_pkg::rorr_tag_t       next_tag,
  // register port
  input  wire rorr_pkg::rorr_addr_t reg_addr,
  input  wire rorr_pkg::rorr_data_t reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output rorr_pkg::rorr_data_t      reg_rdata,
  // interrupt
  output logic                      irq
);
  import rorr_pkg::*;

  // ==========================================================================
  // declarations
  rorr_state_e state;
  rorr_state_e next_state;
  logic        init_meta;
  logic        init_sync;
  logic [1:0]  ctrl;
  rorr_int_t   int_status;
  rorr_int_t   int_mask;
  rorr_int_t   int_event;
  rorr_data_t  next_rdata;
  rorr_tag_t   oldest_tag;
  logic        port_en;
  logic        retry_ok;
  logic        stop_done;
  logic        rec_updated;
  logic        rec_err;
  logic        rec_update;
  logic        rec_finish;
  logic        sel_ctrl;
  logic        sel_int_status;
  logic        sel_int_mask;

  // ==========================================================================
  // init pin synchroniser
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      init_meta <= 1'b0;
      init_sync <= 1'b0;
    end else begin
      init_meta <= init_done;
      init_sync <= init_meta;
    end
  end

  // ==========================================================================
  // machine conditions
  assign port_en    = init_sync && ctrl[CTRL_EN_BIT];
  assign retry_ok   = rx_retry_valid && !rx_sym_err;
  assign stop_done  = !tx_pkt_active;
  assign rec_err    = (state == st_replay_prep) && (rx_pna_valid || tx_port_err);
  assign rec_update = (state == st_replay_prep) && !rec_updated && !rec_err;
  assign rec_finish = (state == st_replay_prep) && rec_updated && !rec_err
                      && tx_pkt_start && (tx_pkt_tag == replay_tag);

  // ==========================================================================
  // state machine
  always_comb begin
    next_state = state;
    unique case (state)
      st_inactive: begin
        if (port_en) begin
          next_state = st_armed;
        end
      end
      st_armed: begin
        if (!port_en) begin
          next_state = st_inactive;
        end else if (retry_ok) begin
          next_state = st_halting;
        end
      end
      st_halting: begin
        if (stop_done) begin
          next_state = st_replay_prep;
        end
      end
      st_replay_prep: begin
        if (rec_err || rec_finish) begin
          next_state = st_armed;
        end
      end
      default: begin
        next_state = st_inactive;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_inactive;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // captured refused tag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      replay_tag <= TAG_RESET;
    end else if (state == st_armed && port_en && retry_ok) begin
      replay_tag <= rx_retry_tag;
    end
  end

  // ==========================================================================
  // replay preparation progress
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rec_updated <= 1'b0;
    end else if (state != st_replay_prep) begin
      rec_updated <= 1'b0;
    end else if (rec_update) begin
      rec_updated <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      send_restart <= 1'b0;
    end else begin
      send_restart <= rec_update;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      err_handoff <= 1'b0;
    end else begin
      err_handoff <= rec_err;
    end
  end

  // ==========================================================================
  // port status flags
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      link_ok <= 1'b0;
    end else if (state == st_armed && port_en && retry_ok) begin
      link_ok <= 1'b0;
    end else if (rec_update) begin
      link_ok <= 1'b1;
    end else if (state == st_inactive && port_en) begin
      link_ok <= 1'b1;
    end else if (state == st_armed && !port_en) begin
      link_ok <= 1'b0;
    end else if (err_done && state == st_armed) begin
      link_ok <= 1'b1;
    end
  end

  // replay_halt also stops the transmitter from starting new packets
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      replay_halt <= 1'b0;
    end else if (state == st_armed && port_en && retry_ok) begin
      replay_halt <= 1'b1;
    end else if (rec_update || rec_err) begin
      replay_halt <= 1'b0;
    end
  end

  // optional cut-off of the packet in flight
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_abort <= 1'b0;
    end else begin
      tx_abort <= (next_state == st_halting) && ctrl[CTRL_ABORT_BIT];
    end
  end

  // ==========================================================================
  // sequence tag scoreboard
  rorr_scoreboard #(
    .TAG_W      (TAG_W)
  ) u_scoreboard (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .pkt_start  (tx_pkt_start && !send_restart),
    .ack_valid  (rx_ack_valid),
    .ack_tag    (rx_ack_tag),
    .rewind     (send_restart),
    .rewind_tag (replay_tag),
    .next_tag   (next_tag),
    .oldest_tag (oldest_tag)
  );

  // ==========================================================================
  // registers
  assign sel_ctrl       = reg_wr && (reg_addr == REG_CTRL);
  assign sel_int_status = reg_wr && (reg_addr == REG_INT_STATUS);
  assign sel_int_mask   = reg_wr && (reg_addr == REG_INT_MASK);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
    end else if (sel_ctrl) begin
      ctrl <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_mask <= INT_RESET;
    end else if (sel_int_mask) begin
      int_mask <= reg_wdata[INT_W-1:0];
    end
  end

  always_comb begin
    int_event                  = INT_RESET;
    int_event[INT_RETRY_BIT]   = (state == st_armed) && port_en && retry_ok;
    int_event[INT_RESUMED_BIT] = rec_finish;
    int_event[INT_HANDOFF_BIT] = rec_err;
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_status <= INT_RESET;
    end else if (sel_int_status) begin
      int_status <= (int_status & ~reg_wdata[INT_W-1:0]) | int_event;
    end else begin
      int_status <= int_status | int_event;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_mask);
    end
  end

  always_comb begin
    next_rdata = DATA_RESET;
    unique case (reg_addr)
      REG_CTRL: begin
        next_rdata[1:0] = ctrl;
      end
      REG_STATUS: begin
        next_rdata[STAT_LINK_OK_BIT]              = link_ok;
        next_rdata[STAT_HALT_BIT]                 = replay_halt;
        next_rdata[STAT_STATE_LSB +: STATE_W]     = state;
      end
      REG_INT_STATUS: begin
        next_rdata[INT_W-1:0] = int_status;
      end
      REG_INT_MASK: begin
        next_rdata[INT_W-1:0] = int_mask;
      end
      REG_TAGS: begin
        next_rdata[TAGS_RETRY_LSB +: TAG_W]  = replay_tag;
        next_rdata[TAGS_NEXT_LSB +: TAG_W]   = next_tag;
        next_rdata[TAGS_OLDEST_LSB +: TAG_W] = oldest_tag;
      end
      default: begin
        next_rdata = DATA_RESET;
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= DATA_RESET;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= DATA_RESET;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence seq_retry_taken;
    (state == st_armed) && port_en && retry_ok;
  endsequence

  sequence seq_prep_entered;
    (state == st_halting) && stop_done ##1 (state == st_replay_prep);
  endsequence

  AST_STAY_INACTIVE: assert property (
    (state == st_inactive) && !port_en |=> (state == st_inactive)
  ) else $error("left inactive without port enable");

  AST_ENABLE_GATED: assert property (
    (state == st_inactive) && !init_sync |=> (state == st_inactive)
  ) else $error("armed before link initialization");

  AST_ARM: assert property (
    (state == st_inactive) && port_en |=> (state == st_armed) && link_ok
  ) else $error("enable did not arm");

  AST_DISARM: assert property (
    (state == st_armed) && !port_en |=> (state == st_inactive)
  ) else $error("disable did not return to inactive");

  AST_BAD_RETRY_IGNORED: assert property (
    (state == st_armed) && port_en && rx_sym_err |=> (state == st_armed)
  ) else $error("errored retry symbol acted upon");

  AST_HALT_FLAGS: assert property (
    seq_retry_taken |=> (state == st_halting) && replay_halt && !link_ok
                        && (replay_tag == $past(rx_retry_tag))
  ) else $error("retry did not halt with flags");

  AST_HALT_HOLDS: assert property (
    (state == st_halting) |-> replay_halt && !link_ok
  ) else $error("flags wrong while halting");

  AST_PREP_STEPS: assert property (
    seq_prep_entered ##0 !rec_err |=> send_restart && link_ok && !replay_halt
                                      ##1 (next_tag == replay_tag)
  ) else $error("replay preparation did not restart and rewind");

  AST_HANDOFF: assert property (
    rec_err |=> err_handoff && (state == st_armed) && !replay_halt
  ) else $error("error during preparation not handed off");

  AST_RETURN: assert property (
    rec_finish |=> (state == st_armed) && int_status[INT_RESUMED_BIT]
  ) else $error("replay start did not rearm");

endmodule : rorr_core
`default_nettype wire

/* tb/rorr_link_partner.sv */
`default_nettype none
// ==========================================================================
// link partner input port: acks in-order packets, refuses on command
module rorr_link_partner
  import rorr_pkg::*;
(
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                nrst,
  // traffic from the block
  input  wire logic                pkt_start,
  input  wire rorr_pkg::rorr_tag_t pkt_tag,
  input  wire logic                restart,
  // test commands
  input  wire logic                refuse,
  input  wire logic                corrupt,
  input  wire logic                slow,
  // symbols back to the block
  output logic                     retry_valid,
  output logic                     sym_err,
  output rorr_pkg::rorr_tag_t      retry_tag,
  output logic                     ack_valid,
  output rorr_pkg::rorr_tag_t      ack_tag
);
  timeunit 1ns;
  timeprecision 1ps;

  rorr_tag_t  exp_tag;
  logic       stopped;
  logic       bad;
  logic [1:0] cnt;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      exp_tag     <= TAG_RESET;
      stopped     <= 1'b0;
      bad         <= 1'b0;
      cnt         <= 2'h0;
      retry_valid <= 1'b0;
      sym_err     <= 1'b0;
      retry_tag   <= TAG_RESET;
      ack_valid   <= 1'b0;
      ack_tag     <= TAG_RESET;
    end else begin
      retry_valid <= 1'b0;
      sym_err     <= 1'b0;
      ack_valid   <= 1'b0;
      // idle symbol fields show the inverted expected tag
      retry_tag   <= ~exp_tag;
      ack_tag     <= ~exp_tag;
      if (restart) begin
        stopped <= 1'b0;
      end
      if (cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
        if (cnt == 2'h1) begin
          retry_valid <= 1'b1;
          sym_err     <= bad;
          retry_tag   <= exp_tag;
        end
      end else if (pkt_start && !stopped) begin
        if (refuse || corrupt) begin
          cnt     <= slow ? 2'h3 : 2'h1;
          bad     <= corrupt;
          stopped <= refuse;
        end else if (pkt_tag == exp_tag) begin
          ack_valid <= 1'b1;
          ack_tag   <= pkt_tag;
          exp_tag   <= exp_tag + 6'h01;
        end
      end
    end
  end
endmodule : rorr_link_partner
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rorr_pkg::*;

  // ==========================================================================
  // signals
  logic       ref_clk = 1'b0;
  logic       nrst    = 1'b0;
  logic       init_done, rx_retry_valid, rx_sym_err, rx_pna_valid, rx_ack_valid;
  logic       tx_pkt_start, tx_pkt_active, tx_port_err, reg_wr, reg_rd;
  logic       link_ok, replay_halt, tx_abort, send_restart, err_handoff, irq;
  logic       refuse, corrupt, slow;
  rorr_tag_t  rx_retry_tag, rx_ack_tag, tx_pkt_tag, replay_tag, next_tag;
  rorr_addr_t reg_addr;
  rorr_data_t reg_wdata, reg_rdata;
  int         mismatches = 0;
  int         total_checks = 0;

  always #20 ref_clk = ~ref_clk;

  rorr_core uut (.ref_clk(ref_clk), .nrst(nrst), .init_done(init_done),
    .rx_retry_valid(rx_retry_valid), .rx_sym_err(rx_sym_err), .rx_retry_tag(rx_retry_tag),
    .rx_pna_valid(rx_pna_valid), .rx_ack_valid(rx_ack_valid), .rx_ack_tag(rx_ack_tag),
    .tx_pkt_start(tx_pkt_start), .tx_pkt_tag(tx_pkt_tag), .tx_pkt_active(tx_pkt_active),
    .tx_port_err(tx_port_err), .err_done(1'b0), .link_ok(link_ok),
    .replay_halt(replay_halt), .tx_abort(tx_abort), .send_restart(send_restart),
    .err_handoff(err_handoff), .replay_tag(replay_tag), .next_tag(next_tag),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));

  rorr_link_partner link (.ref_clk(ref_clk), .nrst(nrst), .pkt_start(tx_pkt_start),
    .pkt_tag(tx_pkt_tag), .restart(send_restart), .refuse(refuse), .corrupt(corrupt),
    .slow(slow), .retry_valid(rx_retry_valid), .sym_err(rx_sym_err),
    .retry_tag(rx_retry_tag), .ack_valid(rx_ack_valid), .ack_tag(rx_ack_tag));

  // ==========================================================================
  // tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input rorr_data_t seen, input rorr_data_t exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input rorr_addr_t a, input rorr_data_t d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input string what, input rorr_addr_t a, input rorr_data_t exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : rd

  task automatic pkt(input rorr_tag_t t, input logic keep);
    @(posedge ref_clk);
    tx_pkt_start  <= 1'b1;
    tx_pkt_tag    <= t;
    tx_pkt_active <= 1'b1;
    @(posedge ref_clk);
    tx_pkt_start  <= 1'b0;
    tx_pkt_active <= keep;
  endtask : pkt

  // bounded wait for send_restart, or err_handoff when sel is set
  task automatic wait_hi(input logic sel);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge ref_clk);
      #1;
      if ((sel ? err_handoff : send_restart) === 1'b1) break;
    end
    if (n == 20) begin
      mismatches++;
      $display("BAD %s expected 1 seen 0", sel ? "err_handoff" : "send_restart");
      summarize();
    end
  endtask : wait_hi

  // ==========================================================================
  // main sequence
  initial begin
    init_done     = 1'b0;
    rx_pna_valid  = 1'b0;
    tx_pkt_start  = 1'b0;
    tx_pkt_active = 1'b0;
    tx_pkt_tag    = TAG_RESET;
    tx_port_err   = 1'b0;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    reg_addr      = REG_CTRL;
    reg_wdata     = DATA_RESET;
    refuse        = 1'b0;
    corrupt       = 1'b0;
    slow          = 1'b0;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    chk("link_ok", 32'(link_ok), 32'h0);
    rd("status", REG_STATUS, 32'h0);
    rd("tags", REG_TAGS, 32'h0);
    rd("unmapped", 8'h14, 32'h0);
    wr(REG_CTRL, 32'h3);
    repeat (4) @(posedge ref_clk);
    rd("status", REG_STATUS, 32'h0);
    init_done <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd("status", REG_STATUS, 32'h11);
    wr(REG_CTRL, 32'h2);
    rd("status", REG_STATUS, 32'h0);
    wr(REG_CTRL, 32'h3);
    rd("ctrl", REG_CTRL, 32'h3);
    for (int i = 0; i < 4; i++) pkt(rorr_tag_t'(i), 1'b0);
    // errored retry symbol must leave the machine armed
    corrupt <= 1'b1;
    pkt(6'h04, 1'b0);
    corrupt <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd("status", REG_STATUS, 32'h11);
    rd("int_status", REG_INT_STATUS, 32'h0);
    // slow refusal while a packet is still on the wire
    slow   <= 1'b1;
    refuse <= 1'b1;
    pkt(6'h05, 1'b1);
    refuse <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rd("status", REG_STATUS, 32'h22);
    chk("tx_abort", 32'(tx_abort), 32'h1);
    rd("tags", REG_TAGS, 32'h040604);
    tx_pkt_active <= 1'b0;
    wait_hi(1'b0);
    chk("link_ok", 32'(link_ok), 32'h1);
    chk("replay_halt", 32'(replay_halt), 32'h0);
    rd("status", REG_STATUS, 32'h31);
    chk("next_tag", 32'(next_tag), 32'h4);
    rd("tags", REG_TAGS, 32'h040404);
    pkt(6'h04, 1'b0);
    pkt(6'h05, 1'b0);
    repeat (3) @(posedge ref_clk);
    rd("status", REG_STATUS, 32'h11);
    rd("tags", REG_TAGS, 32'h060604);
    rd("int_status", REG_INT_STATUS, 32'h3);
    chk("irq", 32'(irq), 32'h0);
    wr(REG_INT_MASK, 32'h2);
    rd("int_mask", REG_INT_MASK, 32'h2);
    chk("irq", 32'(irq), 32'h1);
    wr(REG_INT_STATUS, 32'h3);
    rd("int_status", REG_INT_STATUS, 32'h0);
    chk("irq", 32'(irq), 32'h0);
    // handoff from preparation: not-accepted symbol, then a port error
    slow <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      refuse <= 1'b1;
      pkt(6'h06, 1'b0);
      refuse <= 1'b0;
      wait_hi(1'b0);
      @(posedge ref_clk);
      rx_pna_valid <= (k == 0);
      tx_port_err  <= (k == 1);
      @(posedge ref_clk);
      rx_pna_valid <= 1'b0;
      tx_port_err  <= 1'b0;
      // the handoff pulse stands only in the cycle after the error
      #1;
      chk("err_handoff", 32'(err_handoff), 32'h1);
      rd("status", REG_STATUS, 32'h11);
    end
    rd("int_status", REG_INT_STATUS, 32'h5);
    wr(REG_INT_MASK, 32'h4);
    rd("int_mask", REG_INT_MASK, 32'h4);
    chk("irq", 32'(irq), 32'h1);
    summarize();
  end
endmodule : tb
`default_nettype wire
